// ### include/aps_pkg.sv
// Shared constants and carrier types of the power stage protection controller.
// Assumes one 200 MHz clock and a 32-bit Avalon-MM register slave.
package aps_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int AR_CYCLES_DEF = 512;

    // ==========================================================
    // Register map (byte addresses, one aligned word each)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_ARCOUNT = 4'h8;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // CTRL fields
    localparam int CTRL_MUTE_BIT = 0;
    localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;

    // STATUS fields
    localparam int ST_LATCH_BIT = 0;
    localparam int ST_HIZ_BIT = 1;
    localparam int ST_ARHOLD_BIT = 2;
    localparam int ST_OC_BIT = 3;
    localparam int ST_UV_BIT = 4;
    localparam int ST_TWARN_BIT = 5;
    localparam int ST_TERR_BIT = 6;
    localparam int ST_MODE_LSB = 8;
    localparam int ST_OUTMODE_BIT = 10;
    localparam int ST_RSTPIN_BIT = 11;

    // ==========================================================
    // Protection mode strap codes {prot_mode_sel0, prot_mode_sel1}
    localparam logic [1:0] MODE_AUTO_RECOVER = 2'h0;
    localparam logic [1:0] MODE_LATCHED = 2'h1;
    localparam logic [1:0] MODE_PROT_OFF = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;
    localparam logic OUTMODE_BTL = 1'h0;

    // ==========================================================
    // Carriers
    typedef enum logic [1:0] {
        PS_RUN,
        PS_LATCHED,
        PS_AR_HOLD
    } aps_state_t;

    typedef struct packed {
        logic [1:0] oc_high; // Forward overcurrent, high-side switch, per half-bridge
        logic [1:0] oc_low;  // Forward overcurrent, low-side switch, per half-bridge
        logic uv;            // Gate supply below lockout level
        logic temp_warn;     // Junction above warning threshold
        logic temp_error;    // Junction above error threshold
    } aps_det_t;

    typedef struct packed {
        logic [1:0] high;
        logic [1:0] low;
    } aps_gate_t;

endpackage : aps_pkg

// ### hw/aps_prot_ctrl.sv
// Protection and control logic of a two half-bridge audio power stage.
// Assumes all pins and detector levels are synchronous to clk; the front end
// supplies switching pwm_input and the active-low amp_reset_n.
`timescale 1ns/100ps

module aps_prot_ctrl #(
    parameter int AR_CYCLES = aps_pkg::AR_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic amp_reset_n,
    input wire logic [1:0] pwm_input,
    input wire aps_pkg::aps_det_t det,
    input wire logic prot_mode_sel0,
    input wire logic prot_mode_sel1,
    input wire logic output_mode_sel,
    output aps_pkg::aps_gate_t gate_q,
    output logic fault_status_n_o_q,
    output logic fault_status_n_oe_q,
    output logic temp_warning_n_o_q,
    output logic temp_warning_n_oe_q,
    input wire logic [aps_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [aps_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [aps_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest
);

    localparam int CW = $clog2(AR_CYCLES);
    localparam logic [CW-1:0] HALF_M1 = CW'(AR_CYCLES / 2 - 1);
    localparam logic [CW-1:0] FULL_M1 = CW'(AR_CYCLES - 1);

    // ==========================================================
    // Elaboration check
    if (AR_CYCLES < 4 || (AR_CYCLES % 2) != 0 || AR_CYCLES > 65536) begin : g_bad_ar
        $error("AR_CYCLES must be even and within 4..65536");
    end

    // ==========================================================
    // Strap decode and error detection
    logic [1:0] mode;
    logic mode_off;
    logic mode_ar;
    logic err_event;
    logic pwm_prev_q;
    logic pwm_rise;
    logic rst_pin_prev_q;
    logic rst_fall;
    logic mute_q;

    assign mode = {prot_mode_sel0, prot_mode_sel1};
    assign mode_off = (mode == aps_pkg::MODE_PROT_OFF);
    // Reserved strap code behaves as latching shutdown, the safer choice
    assign mode_ar = (mode == aps_pkg::MODE_AUTO_RECOVER);
    // Any of the four switch sensors, the shared UV and temperature error detectors
    assign err_event = !mode_off && (|det.oc_high || |det.oc_low
                                     || det.uv || det.temp_error);

    // Half-bridge A paces the shared counter; both bridges share one rate
    assign pwm_rise = pwm_input[0] && !pwm_prev_q;
    assign rst_fall = rst_pin_prev_q && !amp_reset_n;

    always_ff @(posedge clk) begin
        if (reset) begin
            pwm_prev_q <= 1'b0;
            rst_pin_prev_q <= 1'b0;
        end else begin
            pwm_prev_q <= pwm_input[0];
            rst_pin_prev_q <= amp_reset_n;
        end
    end

    // ==========================================================
    // Protection state and autorecovery counter
    aps_pkg::aps_state_t state_q;
    aps_pkg::aps_state_t state_d;
    logic [CW-1:0] ar_cnt_q;
    logic [CW-1:0] ar_cnt_d;
    logic hiz_d;

    always_comb begin
        state_d = state_q;
        ar_cnt_d = ar_cnt_q;
        if (err_event) begin
            // A new error wins over any clear in the same cycle
            state_d = aps_pkg::PS_LATCHED;
            ar_cnt_d = '0;
        end else if (mode_off) begin
            state_d = aps_pkg::PS_RUN;
            ar_cnt_d = '0;
        end else if (!amp_reset_n || rst_fall) begin
            // Clearing also while held low lets a late-clearing fault recover
            state_d = aps_pkg::PS_RUN;
            ar_cnt_d = '0;
        end else begin
            unique case (state_q)
                aps_pkg::PS_RUN: begin
                    ar_cnt_d = '0;
                end
                aps_pkg::PS_LATCHED: begin
                    if (mode_ar && pwm_rise) begin
                        ar_cnt_d = ar_cnt_q + 1'b1;
                        if (ar_cnt_q == HALF_M1) begin
                            state_d = aps_pkg::PS_AR_HOLD;
                        end
                    end
                end
                aps_pkg::PS_AR_HOLD: begin
                    if (!mode_ar) begin
                        // Strap moved away from autorecovery: wait for a reset pulse
                        state_d = aps_pkg::PS_LATCHED;
                    end else if (pwm_rise) begin
                        ar_cnt_d = ar_cnt_q + 1'b1;
                        if (ar_cnt_q == FULL_M1) begin
                            state_d = aps_pkg::PS_RUN;
                            ar_cnt_d = '0;
                        end
                    end
                end
                default: begin
                    state_d = aps_pkg::PS_LATCHED;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= aps_pkg::PS_RUN;
            ar_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            ar_cnt_q <= ar_cnt_d;
        end
    end

    // ==========================================================
    // Output stage drive
    assign hiz_d = !amp_reset_n
                   || state_d != aps_pkg::PS_RUN
                   || output_mode_sel != aps_pkg::OUTMODE_BTL
                   || mute_q;

    // Low-side gate follows the inverted PWM so bootstrap recharges each cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            gate_q <= '0;
        end else begin
            gate_q.high <= hiz_d ? 2'h0 : pwm_input;
            gate_q.low <= hiz_d ? 2'h0 : ~pwm_input;
        end
    end

    // ==========================================================
    // Open-drain status pins: pad only ever pulls low
    always_ff @(posedge clk) begin
        if (reset) begin
            fault_status_n_o_q <= 1'b0;
            fault_status_n_oe_q <= 1'b0;
            temp_warning_n_o_q <= 1'b0;
            temp_warning_n_oe_q <= 1'b0;
        end else begin
            fault_status_n_o_q <= 1'b0;
            temp_warning_n_o_q <= 1'b0;
            // Forced released while reset pin is low, whatever is latched
            fault_status_n_oe_q <= amp_reset_n
                                   && state_d == aps_pkg::PS_LATCHED;
            // Error threshold lies above warning threshold, so both pull low
            temp_warning_n_oe_q <= det.temp_warn || det.temp_error;
        end
    end

    // ==========================================================
    // Avalon-MM slave: one wait cycle, answer on the second edge
    logic [aps_pkg::DATA_W-1:0] status_w;
    logic [aps_pkg::DATA_W-1:0] rd_d;
    logic req;

    assign req = avs_read || avs_write;

    always_comb begin
        status_w = '0;
        status_w[aps_pkg::ST_LATCH_BIT] = (state_q == aps_pkg::PS_LATCHED);
        status_w[aps_pkg::ST_HIZ_BIT] = (gate_q == '0);
        status_w[aps_pkg::ST_ARHOLD_BIT] = (state_q == aps_pkg::PS_AR_HOLD);
        status_w[aps_pkg::ST_OC_BIT] = |det.oc_high || |det.oc_low;
        status_w[aps_pkg::ST_UV_BIT] = det.uv;
        status_w[aps_pkg::ST_TWARN_BIT] = det.temp_warn;
        status_w[aps_pkg::ST_TERR_BIT] = det.temp_error;
        status_w[aps_pkg::ST_MODE_LSB +: 2] = mode;
        status_w[aps_pkg::ST_OUTMODE_BIT] = output_mode_sel;
        status_w[aps_pkg::ST_RSTPIN_BIT] = amp_reset_n;
    end

    always_comb begin
        unique case (avs_address)
            aps_pkg::REG_CTRL: begin
                rd_d = {31'h0000_0000, mute_q};
            end
            aps_pkg::REG_STATUS: begin
                rd_d = status_w;
            end
            aps_pkg::REG_ARCOUNT: begin
                rd_d = 32'(ar_cnt_q);
            end
            default: begin
                rd_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
        end else begin
            // Low for exactly one cycle, then high again for the next request
            avs_waitrequest <= !(req && avs_waitrequest);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            avs_readdata <= '0;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= rd_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mute_q <= aps_pkg::CTRL_RESET_VAL[aps_pkg::CTRL_MUTE_BIT];
        end else if (avs_write && !avs_waitrequest && avs_byteenable[0]
                     && avs_address == aps_pkg::REG_CTRL) begin
            mute_q <= avs_writedata[aps_pkg::CTRL_MUTE_BIT];
        end
    end

    // ==========================================================
    // Checks
    a_reset_pin_hiz: assert property (@(posedge clk) disable iff (reset)
        !amp_reset_n |=> gate_q == '0)
        else $error("switch driven while reset pin low");

    a_fault_forced_high: assert property (@(posedge clk) disable iff (reset)
        !amp_reset_n |=> !fault_status_n_oe_q)
        else $error("fault pin pulled while reset pin low");

    a_fault_on_latch: assert property (@(posedge clk) disable iff (reset)
        amp_reset_n && err_event |=> fault_status_n_oe_q && !fault_status_n_o_q)
        else $error("latched error not reported");

    a_warn_follows_temp: assert property (@(posedge clk) disable iff (reset)
        det.temp_warn != $past(det.temp_warn) && !det.temp_error
        |=> temp_warning_n_oe_q == $past(det.temp_warn))
        else $error("warning pin does not follow temperature");

    a_error_sets_hiz: assert property (@(posedge clk) disable iff (reset)
        err_event |=> state_q == aps_pkg::PS_LATCHED && gate_q == '0 [*2])
        else $error("error did not force Hi-Z");

    a_fall_clears_latch: assert property (@(posedge clk) disable iff (reset)
        state_q == aps_pkg::PS_LATCHED && rst_fall && !err_event
        |=> state_q == aps_pkg::PS_RUN)
        else $error("reset fall did not clear latch");

    a_ar_half_clear: assert property (@(posedge clk) disable iff (reset)
        state_q == aps_pkg::PS_LATCHED && mode_ar && amp_reset_n && !err_event
        && pwm_rise && ar_cnt_q == HALF_M1
        |=> state_q == aps_pkg::PS_AR_HOLD && gate_q == '0 && !fault_status_n_oe_q)
        else $error("latch not cleared at half count");

    a_ar_resume: assert property (@(posedge clk) disable iff (reset)
        state_q == aps_pkg::PS_AR_HOLD && mode_ar && amp_reset_n && !err_event
        && pwm_rise && ar_cnt_q == FULL_M1 |=> state_q == aps_pkg::PS_RUN)
        else $error("no resume at full count");

    a_ar_count_step: assert property (@(posedge clk) disable iff (reset)
        state_q != aps_pkg::PS_RUN && mode_ar && amp_reset_n && !err_event
        && pwm_rise && ar_cnt_q != FULL_M1 |=> ar_cnt_q == $past(ar_cnt_q) + 1'b1)
        else $error("counter did not step on PWM edge");

    a_ar_restart: assert property (@(posedge clk) disable iff (reset)
        err_event |=> ar_cnt_q == '0)
        else $error("counter not restarted by error");

    a_latched_holds: assert property (@(posedge clk) disable iff (reset)
        state_q == aps_pkg::PS_LATCHED && mode == aps_pkg::MODE_LATCHED
        && amp_reset_n |=> state_q == aps_pkg::PS_LATCHED)
        else $error("latched shutdown left without reset pulse");

    a_off_ignores: assert property (@(posedge clk) disable iff (reset)
        mode_off |=> state_q == aps_pkg::PS_RUN)
        else $error("detector acted in protection-off mode");

    a_outmode_reserved: assert property (@(posedge clk) disable iff (reset)
        output_mode_sel |=> gate_q == '0)
        else $error("switching in reserved output mode");

    a_hold_released: assert property (@(posedge clk) disable iff (reset)
        state_q == aps_pkg::PS_AR_HOLD |-> !fault_status_n_oe_q && gate_q == '0)
        else $error("autorecovery hold not released and Hi-Z");

    a_warn_on_error: assert property (@(posedge clk) disable iff (reset)
        det.temp_error |=> temp_warning_n_oe_q)
        else $error("temperature error not shown on warning pin");

    c_ar_full: cover property (@(posedge clk) disable iff (reset)
        state_q == aps_pkg::PS_AR_HOLD ##1 state_q == aps_pkg::PS_RUN);
    c_latched_fault: cover property (@(posedge clk) disable iff (reset)
        mode == aps_pkg::MODE_LATCHED && fault_status_n_oe_q);
    c_reset_recover: cover property (@(posedge clk) disable iff (reset)
        state_q == aps_pkg::PS_LATCHED && rst_fall ##[1:100] amp_reset_n);
    c_temp_error: cover property (@(posedge clk) disable iff (reset)
        fault_status_n_oe_q && temp_warning_n_oe_q);

endmodule : aps_prot_ctrl

// ### tb/aps_front_model.sv
// Front-end model: PWM modulator that sequences the amplifier reset pin.
// Assumes the controller's clock; all outputs change right after rising edges.
`timescale 1ns/100ps
module aps_front_model #(
    parameter int PERIOD = 10,
    parameter int HOLD = 40
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic en,
    input wire logic [7:0] duty,
    output logic [1:0] pwm_input,
    output logic amp_reset_n
);
    logic [7:0] ph_q;
    logic [7:0] hold_q;
    logic run_q;

    // ==========================================================
    // PWM generator; stopped outputs park low, never high
    always_ff @(posedge clk) begin
        if (reset || !run_q) begin
            ph_q <= 8'h00;
            pwm_input <= 2'h0;
        end else begin
            ph_q <= (ph_q == 8'(PERIOD - 1)) ? 8'h00 : ph_q + 8'h01;
            pwm_input[0] <= ph_q < duty;
            pwm_input[1] <= ph_q >= duty;
        end
    end

    // ==========================================================
    // Reset sequencing: PWM first, reset later; on stop the reverse
    always_ff @(posedge clk) begin
        if (reset) begin
            run_q <= 1'b0;
            hold_q <= 8'h00;
            amp_reset_n <= 1'b0;
        end else if (en) begin
            run_q <= 1'b1;
            if (hold_q == 8'(HOLD)) begin
                amp_reset_n <= 1'b1;
            end else begin
                hold_q <= hold_q + 8'h01;
            end
        end else begin
            amp_reset_n <= 1'b0;
            hold_q <= 8'h00;
            if (!amp_reset_n) begin
                run_q <= 1'b0;
            end
        end
    end
endmodule : aps_front_model

// ### tb/tb_aps_prot_ctrl.sv
// Self-checking bench of the protection controller with a front-end model.
// Assumes aps_pkg is compiled first; autorecovery shortened to 8 PWM cycles.
`timescale 1ns/100ps
module tb_aps_prot_ctrl;
    logic clk, reset, en, sel0, sel1, out_sel, avs_read, avs_write, avs_waitrequest;
    logic amp_reset_n, fault_o, fault_oe, warn_o, warn_oe;
    logic [1:0] pwm_input;
    logic [7:0] duty;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q, rnd;
    aps_pkg::aps_det_t det;
    aps_pkg::aps_gate_t gate;
    int num_errors, samples_checked;

    aps_front_model aps_front_model_inst (.clk(clk), .reset(reset), .en(en), .duty(duty),
        .pwm_input(pwm_input), .amp_reset_n(amp_reset_n));
    aps_prot_ctrl #(.AR_CYCLES(8)) aps_prot_ctrl_inst (.clk(clk), .reset(reset),
        .amp_reset_n(amp_reset_n), .pwm_input(pwm_input), .det(det),
        .prot_mode_sel0(sel0), .prot_mode_sel1(sel1), .output_mode_sel(out_sel),
        .gate_q(gate), .fault_status_n_o_q(fault_o), .fault_status_n_oe_q(fault_oe),
        .temp_warning_n_o_q(warn_o), .temp_warning_n_oe_q(warn_oe),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
    endfunction : lfsr

    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Request is held until the rising edge at which waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        chk(n < 100, 1'b1);
    endtask : bus

    task automatic wait_rst(input logic v);
        int n;
        n = 0;
        while (amp_reset_n !== v && n < 500) begin
            @(negedge clk);
            n++;
        end
        chk(amp_reset_n, v);
    endtask : wait_rst

    task automatic wait_rise();
        logic p;
        int n;
        n = 0;
        do begin
            p = pwm_input[0];
            @(negedge clk);
            n++;
        end while (!(pwm_input[0] && !p) && n < 100);
    endtask : wait_rise

    task automatic follow();
        logic [1:0] p;
        @(negedge clk);
        p = pwm_input;
        @(negedge clk);
        chk({28'h0, gate}, {28'h0, p, ~p});
    endtask : follow

    task automatic start_amp();
        rnd = lfsr(rnd);
        @(posedge clk);
        duty <= 8'(1 + rnd % 9);
        en <= 1'b1;
        wait_rst(1'b1);
        follow();
    endtask : start_amp

    task automatic stop_amp();
        @(posedge clk);
        en <= 1'b0;
        wait_rst(1'b0);
        @(negedge clk);
        chk({gate, fault_oe}, 5'h00);
        bus(1'b0, aps_pkg::REG_STATUS, 32'h0);
        chk(q[aps_pkg::ST_LATCH_BIT], 1'b0);
    endtask : stop_amp

    // Pulse one detector bit for one cycle, look one edge on while the pins stand
    task automatic fire(input int i, input logic exp_f, input logic exp_w);
        @(posedge clk);
        det <= 7'(1 << i);
        @(posedge clk);
        det <= '0;
        @(negedge clk);
        chk({warn_o, fault_o, warn_oe, fault_oe}, {2'h0, exp_w, exp_f});
    endtask : fire

    // ==========================================================
    // Clock, watchdog and main sequence
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        test_done();
    end

    initial begin
        {reset, en, sel0, sel1, out_sel, avs_read, avs_write} = 7'h40;
        {avs_address, avs_writedata, duty, det} = '0;
        rnd = 32'h853D;
        num_errors = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk({gate, fault_oe, warn_oe, avs_waitrequest}, 7'h01);
        bus(1'b0, aps_pkg::REG_CTRL, 32'h0);
        chk(q, aps_pkg::CTRL_RESET_VAL);
        bus(1'b0, 4'hC, 32'h0);
        chk(q, 32'h0);
        // Latching code and reserved code, every error source
        for (int m = 1; m <= 3; m += 2) begin
            @(posedge clk);
            {sel0, sel1} <= 2'(m);
            for (int i = 0; i < 7; i++) begin
                if (i == 1) continue;
                start_amp();
                rnd = lfsr(rnd);
                repeat (rnd % 7) @(posedge clk);
                fire(i, 1'b1, i == 0);
                repeat (30) @(posedge clk);
                @(negedge clk);
                chk({gate, fault_oe}, 5'h01);
                bus(1'b0, aps_pkg::REG_STATUS, 32'h0);
                chk({q[9:8], q[0]}, {2'(m), 1'b1});
                stop_amp();
            end
        end
        // Autorecovery paced by PWM rises
        @(posedge clk);
        {sel0, sel1} <= aps_pkg::MODE_AUTO_RECOVER;
        start_amp();
        wait_rise();
        fire(2, 1'b1, 1'b0);
        for (int k = 1; k <= 8; k++) begin
            wait_rise();
            if (k == 4) begin
                chk(fault_oe, 1'b1);
                @(negedge clk);
                @(negedge clk);
                chk({gate, fault_oe}, 5'h00);
                bus(1'b0, aps_pkg::REG_ARCOUNT, 32'h0);
                chk(q, 32'(k));
            end
            if (k == 8) begin
                chk({28'h0, gate}, 32'h0);
            end
        end
        @(negedge clk);
        follow();
        stop_amp();
        // Protection disabled: detectors ignored, warning still reported
        @(posedge clk);
        {sel0, sel1} <= aps_pkg::MODE_PROT_OFF;
        start_amp();
        fire(2, 1'b0, 1'b0);
        fire(6, 1'b0, 1'b0);
        follow();
        @(posedge clk);
        det.temp_warn <= 1'b1;
        repeat (3) @(negedge clk);
        chk({warn_oe, fault_oe}, 2'h2);
        @(posedge clk);
        det.temp_warn <= 1'b0;
        repeat (3) @(negedge clk);
        chk({warn_oe, fault_oe}, 2'h0);
        // Mute bit and reserved output mode force Hi-Z without fault
        bus(1'b1, aps_pkg::REG_CTRL, 32'h1);
        repeat (2) @(negedge clk);
        chk({gate, fault_oe}, 5'h00);
        bus(1'b1, aps_pkg::REG_CTRL, 32'h0);
        follow();
        @(posedge clk);
        out_sel <= 1'b1;
        repeat (3) @(negedge clk);
        chk({gate, fault_oe}, 5'h00);
        @(posedge clk);
        out_sel <= aps_pkg::OUTMODE_BTL;
        follow();
        stop_amp();
        test_done();
    end
endmodule : tb_aps_prot_ctrl
